// ===== rtl/ipp_top.sv
// Purpose: Three-stage instruction prefetch pipe fed from a long-word holding register, the cache or the bus.
// Assumes: Sequencer, cache and bus controller are logic on the same clock.
// Notes: One prefetch in flight; the sequencer stalls on o_pf_busy until it ends.
`timescale 1ns/1ps
module ipp_top (
  // Clock and reset.
  input wire logic i_clk_sys,
  input wire logic i_nrst,
  // Sequencer prefetch request and pipe control.
  input wire logic i_pf_req,
  input wire logic [31:0] i_pf_addr,
  input wire logic i_flow_change,
  input wire logic i_consume,
  output logic o_pf_busy,
  output logic o_pf_done,
  // Decode outputs from stage D, plus the words and valids of stages C and B.
  output logic o_dec_valid,
  output logic [15:0] o_dec_word,
  output logic o_dec_fault,
  output logic [15:0] o_word_c,
  output logic o_valid_c,
  output logic [15:0] o_word_b,
  output logic o_valid_b,
  // Instruction cache lookup.
  output logic o_ic_req,
  output logic [31:0] o_ic_addr,
  input wire logic i_ic_hit,
  input wire logic [31:0] i_ic_data,
  // Bus controller.
  output logic o_bc_req,
  output logic [31:0] o_bc_addr,
  output logic o_bc_abort,
  input wire logic i_bc_done,
  input wire logic i_bc_err,
  input wire logic [31:0] i_bc_data
);

  ipp_pkg::ipp_state_e st_reg; // Fetch engine state.
  ipp_pkg::ipp_state_e st_next;
  logic [31:0] addr_reg; // Address of the fetch in flight.
  logic [31:0] addr_next;
  logic hold_hit; // Holding register hit for the current request.
  logic [15:0] hold_word; // Word selected from the holding register.
  logic hold_fault; // Fault status of the held long word.
  logic fill; // Long word arrives this cycle.
  logic [31:0] fill_addr; // Address for that long word.
  ipp_pkg::ipp_long_s fill_d; // The arriving long word.
  logic word_ok; // A word is ready to enter stage B.
  ipp_pkg::ipp_stage_s in_word; // Word offered to stage B.
  ipp_pkg::ipp_stage_s st_q [ipp_pkg::STAGES]; // Stage contents B, C, D.
  ipp_pkg::ipp_stage_s st_d [ipp_pkg::STAGES]; // Stage inputs.
  logic [ipp_pkg::STAGES-1:0] st_ld; // Stage loads.
  logic adv; // Pipe shifts one place.
  logic new_req; // A fresh request is taken.

  // Requests are taken only while idle; flow change kills everything.
  assign new_req = i_pf_req && (st_reg == ipp_pkg::ST_IDLE) && !i_flow_change; // RULE12

  // The request is offered to holder, cache and bus in the same cycle.
  assign o_ic_req = new_req; // RULE10
  assign o_ic_addr = i_pf_addr;

  ipp_holder u_holder (
    .i_clk_sys(i_clk_sys),
    .i_nrst(i_nrst),
    .i_addr(i_pf_addr),
    .i_req(new_req),
    .o_hit(hold_hit),
    .o_word(hold_word),
    .o_fault(hold_fault),
    .i_fill(fill),
    .i_fill_addr(fill_addr),
    .i_fill_d(fill_d),
    .i_inval(i_flow_change)
  );

  // The bus sees the request in the same cycle; a holder hit aborts it at once.
  assign o_bc_req = new_req; // RULE10 RULE13
  assign o_bc_addr = i_pf_addr;
  // A bus cycle that started for a holder hit is cancelled in that cycle.
  assign o_bc_abort = new_req && hold_hit; // RULE11

  // Fetch engine next-state logic.
  always_comb begin
    st_next = st_reg;
    addr_next = addr_reg;
    fill = 1'b0;
    fill_addr = addr_reg;
    fill_d = '{fault: 1'b0, data: i_bc_data};
    word_ok = 1'b0;
    in_word = '{valid: 1'b1, fault: 1'b0, word: ipp_pkg::WORD_RST};
    unique case (st_reg)
      ipp_pkg::ST_IDLE: begin
        if (new_req) begin
          addr_next = i_pf_addr;
          if (hold_hit) begin
            // Sequential word from the holder; no cache or bus access needed.
            word_ok = 1'b1; // RULE8 RULE9
            in_word.word = hold_word;
            in_word.fault = hold_fault; // RULE4
          end else if (i_ic_hit) begin
            // Whole long word from the cache; addressed word to stage B.
            fill = 1'b1; // RULE7
            fill_addr = i_pf_addr;
            fill_d = '{fault: 1'b0, data: i_ic_data};
            word_ok = 1'b1;
            in_word.word = i_pf_addr[ipp_pkg::WSEL_BIT] ? i_ic_data[15:0] : i_ic_data[31:16];
          end else begin
            // Miss: the sequencer stalls until the bus cycle ends.
            st_next = ipp_pkg::ST_WAIT; // RULE14
          end
        end
      end
      ipp_pkg::ST_WAIT: begin
        if (i_flow_change) begin
          st_next = ipp_pkg::ST_IDLE; // RULE17
        end else if (i_bc_done || i_bc_err) begin
          // Faulted data is kept but flagged; the fault is raised only at decode.
          fill = 1'b1; // RULE7 RULE15
          fill_d = '{fault: i_bc_err, data: i_bc_data};
          word_ok = 1'b1;
          in_word.fault = i_bc_err; // RULE4
          in_word.word = addr_reg[ipp_pkg::WSEL_BIT] ? i_bc_data[15:0] : i_bc_data[31:16];
          st_next = ipp_pkg::ST_IDLE;
        end
      end
      default: begin
        st_next = ipp_pkg::ST_IDLE;
      end
    endcase
  end

  // Fetch engine registers.
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      st_reg <= ipp_pkg::ST_IDLE;
      addr_reg <= 32'h0000_0000;
    end else begin
      st_reg <= st_next;
      addr_reg <= addr_next;
    end
  end

  // The pipe shifts only when a prefetched word arrives, never on its own.
  assign adv = word_ok && !i_flow_change; // RULE5

  // Stage wiring: B takes the new word, C takes B, D takes C.
  always_comb begin
    st_d[0] = in_word; // RULE2
    st_d[1] = st_q[0];
    st_d[2] = st_q[1];
    st_ld = '0;
    if (adv) begin
      st_ld = '1; // RULE2
    end else if (i_consume && st_q[2].valid) begin
      // Decode took D; mark it empty so it is not decoded twice.
      st_d[2] = '{valid: 1'b0, fault: 1'b0, word: st_q[2].word};
      st_ld[2] = 1'b1;
    end
  end

  // Three 16-bit stages with valid and fault status.
  for (genvar g = 0; g < ipp_pkg::STAGES; g++) begin : g_stage
    ipp_stage u_stage (
      .i_clk_sys(i_clk_sys),
      .i_nrst(i_nrst),
      .i_load(st_ld[g]),
      .i_flush(i_flow_change), // RULE17
      .i_d(st_d[g]),
      .o_q(st_q[g])
    ); // RULE1 RULE6
  end

  // Handshake back to the sequencer.
  assign o_pf_busy = (st_reg == ipp_pkg::ST_WAIT); // RULE14
  assign o_pf_done = adv;

  // Only stage D presents a decoded word, and a fault only there.
  assign o_dec_valid = st_q[2].valid; // RULE3
  assign o_dec_word = st_q[2].word;
  assign o_dec_fault = st_q[2].valid && st_q[2].fault; // RULE16
  assign o_word_c = st_q[1].word;
  assign o_valid_c = st_q[1].valid;
  assign o_word_b = st_q[0].word;
  assign o_valid_b = st_q[0].valid;

endmodule

// ===== rtl/ipp_pkg.sv
// Purpose: Shared constants and carrier types for the instruction prefetch pipe.
// Assumes: One clock, asynchronous active-low reset.
// Notes: Function
// Function
// RULE1: Exactly three decode stages in the pipe.
// RULE2: Words enter B, then C, then D.
// RULE3: Word decoded only once in stage D.
// RULE4: Each stage holds an abnormal-termination flag.
// RULE5: Stages load only on sequencer prefetch request.
// RULE6: Stages 16 bits, holding register 32 bits.
// RULE7: Even prefetch loads long word, upper to B.
// RULE8: Next sequential prefetch served from holding register.
// RULE9: Holding register serves with cache on or off.
// RULE10: Request goes to holder, cache, bus together.
// RULE11: Holding hit aborts any started bus cycle.
// RULE12: Sequencer originates prefetches and validates stages.
// RULE13: Bus cycles only at sequencer direction.
// RULE14: Sequencer runs or stalls awaiting accesses.
// RULE15: Bus error suspends, handler, rerun, continue.
// RULE16: Fault flag travels, signalled only at D.
// RULE17: Flow change or reset invalidates everything.
package ipp_pkg;

  // Width of one pipe stage in bits.
  localparam int unsigned WORD_W = 16;
  // Width of the holding register in bits.
  localparam int unsigned LONG_W = 32;
  // Address width of the byte-granular fetch address.
  localparam int unsigned ADDR_W = 32;
  // Number of decode stages.
  localparam int unsigned STAGES = 3;
  // Bit position of the word-select bit within a byte address.
  localparam int unsigned WSEL_BIT = 1;
  // Reset value of every stage word.
  localparam logic [15:0] WORD_RST = 16'h0000;
  // Reset value of the holding register.
  localparam logic [31:0] LONG_RST = 32'h0000_0000;

  // One pipe stage: valid, fault flag and instruction word.
  typedef struct packed {
    logic valid;
    logic fault;
    logic [15:0] word;
  } ipp_stage_s;

  // A long word as returned by cache or bus, with its fault status.
  typedef struct packed {
    logic fault;
    logic [31:0] data;
  } ipp_long_s;

  // Fetch engine states.
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_WAIT = 2'b01
  } ipp_state_e;

endpackage

// ===== rtl/ipp_stage.sv
// Purpose: One instruction pipe stage with valid and fault status.
// Assumes: Load and flush come from the pipe controller on the same clock.
// Notes: Flush has priority over load so no stale word stays valid after a flow change.
`timescale 1ns/1ps
module ipp_stage (
  // Clock and reset.
  input wire logic i_clk_sys,
  input wire logic i_nrst,
  // Control.
  input wire logic i_load,
  input wire logic i_flush,
  // Incoming word.
  input wire ipp_pkg::ipp_stage_s i_d,
  // Held word.
  output ipp_pkg::ipp_stage_s o_q
);

  ipp_pkg::ipp_stage_s q_reg; // Registered stage content.
  ipp_pkg::ipp_stage_s q_next; // Next stage content.

  // Next value: flush clears valid and fault, load takes word with its flag.
  always_comb begin
    q_next = q_reg;
    if (i_flush) begin
      q_next.valid = 1'b0; // RULE17
      q_next.fault = 1'b0;
    end else if (i_load) begin
      q_next = i_d; // RULE16
    end
  end

  // Stage register.
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      q_reg <= '{valid: 1'b0, fault: 1'b0, word: ipp_pkg::WORD_RST}; // RULE17
    end else begin
      q_reg <= q_next;
    end
  end

  assign o_q = q_reg;

endmodule

// ===== rtl/ipp_holder.sv
// Purpose: 32-bit holding register with tag for the prefetch front end.
// Assumes: Address is a byte address; bit 1 selects the word in a long word.
// Notes: A hit is combinational so the fetch engine can abort in the request cycle.
`timescale 1ns/1ps
module ipp_holder (
  // Clock and reset.
  input wire logic i_clk_sys,
  input wire logic i_nrst,
  // Lookup.
  input wire logic [31:0] i_addr,
  input wire logic i_req,
  output logic o_hit,
  output logic [15:0] o_word,
  output logic o_fault,
  // Fill and invalidate.
  input wire logic i_fill,
  input wire logic [31:0] i_fill_addr,
  input wire ipp_pkg::ipp_long_s i_fill_d,
  input wire logic i_inval
);

  logic valid_reg; // Holds a valid long word.
  logic valid_next;
  logic [29:0] tag_reg; // Long-word address of the held data.
  logic [29:0] tag_next;
  ipp_pkg::ipp_long_s data_reg; // Held long word and its fault status.
  ipp_pkg::ipp_long_s data_next;

  // Hit whether or not the cache is enabled; the holder does not look at it.
  assign o_hit = i_req && valid_reg && (tag_reg == i_addr[31:2]); // RULE9
  // Upper word for even addresses, lower word for odd ones.
  assign o_word = i_addr[ipp_pkg::WSEL_BIT] ? data_reg.data[15:0] : data_reg.data[31:16];
  assign o_fault = data_reg.fault;

  // Next state: invalidate wins over fill.
  always_comb begin
    valid_next = valid_reg;
    tag_next = tag_reg;
    data_next = data_reg;
    if (i_inval) begin
      valid_next = 1'b0; // RULE17
    end else if (i_fill) begin
      valid_next = 1'b1;
      tag_next = i_fill_addr[31:2];
      data_next = i_fill_d; // RULE6
    end
  end

  // Holder registers.
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      valid_reg <= 1'b0;
      tag_reg <= 30'h0;
      data_reg <= '{fault: 1'b0, data: ipp_pkg::LONG_RST};
    end else begin
      valid_reg <= valid_next;
      tag_reg <= tag_next;
      data_reg <= data_next;
    end
  end

endmodule

// ===== testbench/ipp_chk.sv
// Purpose: Port assertions for the instruction prefetch pipe.
// Assumes: Bound into ipp_top; one clock domain.
// Notes: Latencies follow the pipe's hand-over contract.
`timescale 1ns/1ps
module ipp_chk (
  // Clock and reset.
  input wire logic i_clk_sys,
  input wire logic i_nrst,
  // Sequencer side.
  input wire logic i_pf_req,
  input wire logic i_flow_change,
  input wire logic o_pf_busy,
  input wire logic o_pf_done,
  // Pipe stages.
  input wire logic o_dec_valid,
  input wire logic o_dec_fault,
  input wire logic [15:0] o_dec_word,
  input wire logic [15:0] o_word_c,
  input wire logic o_valid_c,
  input wire logic [15:0] o_word_b,
  input wire logic o_valid_b,
  // Cache and bus requests.
  input wire logic o_ic_req,
  input wire logic o_bc_req,
  input wire logic o_bc_abort
);
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_nrst);
  // A request left unanswered in its own cycle must raise o_pf_busy at the next edge.
  sequence s_miss; o_bc_req && !o_bc_abort && !o_pf_done; endsequence
  // A word enters B, so every stage moves on at the next edge.
  sequence s_shift; o_pf_done && !i_flow_change; endsequence
  property p_fan; o_ic_req == o_bc_req; endproperty
  a_fan: assert property (p_fan) else $error("cache and bus requests split");
  property p_why; o_ic_req |-> i_pf_req && !i_flow_change && !o_pf_busy; endproperty
  a_why: assert property (p_why) else $error("fetch without request");
  property p_abort; o_bc_abort |-> o_bc_req && o_pf_done; endproperty
  a_abort: assert property (p_abort) else $error("stray abort");
  property p_miss; s_miss |=> o_pf_busy; endproperty
  a_miss: assert property (p_miss) else $error("miss not busy");
  property p_shift;
    s_shift |=> o_valid_b && o_word_c == $past(o_word_b) && o_valid_c == $past(o_valid_b);
  endproperty
  a_shift: assert property (p_shift) else $error("B to C move wrong");
  property p_dstage;
    s_shift |=> o_dec_word == $past(o_word_c) && o_dec_valid == $past(o_valid_c);
  endproperty
  a_dstage: assert property (p_dstage) else $error("C to D move wrong");
  property p_hold; !o_pf_done && !i_flow_change |=> $stable(o_word_b) && $stable(o_valid_b);
  endproperty
  a_hold: assert property (p_hold) else $error("B changed unasked");
  property p_flush; i_flow_change |=> !(o_valid_b || o_valid_c || o_dec_valid || o_pf_busy);
  endproperty
  a_flush: assert property (p_flush) else $error("flush left state");
  property p_fault; o_dec_fault |-> o_dec_valid; endproperty
  a_fault: assert property (p_fault) else $error("fault on empty D");
  // A flagged word may only reach D by a pipe shift, never appear there on its own.
  property p_fault_move; $rose(o_dec_fault) |-> $past(o_pf_done) && !$past(i_flow_change);
  endproperty
  a_fault_move: assert property (p_fault_move) else $error("fault reached D unshifted");
endmodule
bind ipp_top ipp_chk chk_u (.i_clk_sys(i_clk_sys), .i_nrst(i_nrst), .i_pf_req(i_pf_req),
  .i_flow_change(i_flow_change), .o_pf_busy(o_pf_busy), .o_pf_done(o_pf_done),
  .o_dec_valid(o_dec_valid), .o_dec_fault(o_dec_fault), .o_dec_word(o_dec_word),
  .o_word_c(o_word_c), .o_valid_c(o_valid_c), .o_word_b(o_word_b), .o_valid_b(o_valid_b),
  .o_ic_req(o_ic_req), .o_bc_req(o_bc_req), .o_bc_abort(o_bc_abort));

// ===== testbench/ipp_far.sv
// Purpose: Cache and bus controller model facing the prefetch pipe.
// Assumes: Same clock; latency and faulting long word come from the bench.
// Notes: Idle data lines carry a changing pattern, never the last value.
`timescale 1ns/1ps
module ipp_far (
  // Clock and reset.
  input wire logic i_clk_sys,
  input wire logic i_nrst,
  // Requests from the pipe.
  input wire logic i_ic_req,
  input wire logic [31:0] i_ic_addr,
  input wire logic i_bc_req,
  input wire logic [31:0] i_bc_addr,
  input wire logic i_bc_abort,
  // Bench controls.
  input wire logic i_ic_en,
  input wire logic [7:0] i_lat,
  input wire logic [29:0] i_err_la,
  // Answers.
  output logic o_ic_hit,
  output logic [31:0] o_ic_data,
  output logic o_bc_done,
  output logic o_bc_err,
  output logic [31:0] o_bc_data
);
  bit seen [bit [29:0]]; // Long words the cache holds.
  logic [29:0] la_reg;
  logic [29:0] cyc_reg;
  logic [7:0] cnt_reg;
  // Halves differ, so a swapped word shows at once.
  function automatic logic [31:0] mem(input logic [29:0] l);
    return {l[15:0] ^ 16'ha5a5, l[15:0] ^ 16'h3c3c};
  endfunction
  // The cache answers in the request cycle, only when enabled and filled.
  always @* begin
    o_ic_hit = i_ic_en && i_ic_req && seen.exists(i_ic_addr[31:2]);
    o_ic_data = o_ic_hit ? mem(i_ic_addr[31:2]) : ~mem(cyc_reg);
    o_bc_data = (o_bc_done || o_bc_err) ? mem(la_reg) : mem(cyc_reg);
  end
  // A bus cycle ends after the set latency; an aborted one never starts.
  always @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      cnt_reg <= 8'h00;
      cyc_reg <= 30'h0;
      o_bc_done <= 1'b0;
      o_bc_err <= 1'b0;
    end else begin
      cyc_reg <= cyc_reg + 30'h1;
      o_bc_done <= 1'b0;
      o_bc_err <= 1'b0;
      if (i_bc_req && !i_bc_abort && !o_ic_hit) begin
        cnt_reg <= i_lat;
        la_reg <= i_bc_addr[31:2];
      end else if (cnt_reg == 8'h01) begin
        o_bc_done <= la_reg != i_err_la;
        o_bc_err <= la_reg == i_err_la;
        if (la_reg != i_err_la) seen[la_reg] = 1'b1;
        cnt_reg <= 8'h00;
      end else if (cnt_reg != 8'h00) begin
        cnt_reg <= cnt_reg - 8'h01;
      end
    end
  end
endmodule

// ===== testbench/testbench.sv
// Purpose: Self-checking bench for the instruction prefetch pipe.
// Assumes: The partner model answers for cache and bus.
// Notes: An integer pipe model predicts all stages after each fetch.
`timescale 1ns/1ps
module testbench;
  logic i_clk_sys, i_nrst = 1'b0, i_pf_req = 1'b0, i_flow_change = 1'b0, i_consume = 1'b0;
  logic ic_en = 1'b0, o_pf_busy, o_pf_done, o_dec_valid, o_dec_fault, o_valid_c, o_valid_b;
  logic o_ic_req, o_bc_req, o_bc_abort, ic_hit, bc_done, bc_err;
  logic [31:0] i_pf_addr = 32'h0000_0000, ic_addr, bc_addr, ic_data, bc_data, a;
  logic [29:0] err_la = 30'h3fff_ffff, h_la;
  logic [15:0] o_dec_word, o_word_c, o_word_b;
  logic [7:0] lat = 8'h01;
  int n_mismatch, check_count, hv, pv[3], pw[3], pft[3];
  ipp_top dut_u (.i_clk_sys(i_clk_sys), .i_nrst(i_nrst), .i_pf_req(i_pf_req),
    .i_pf_addr(i_pf_addr), .i_flow_change(i_flow_change), .i_consume(i_consume),
    .o_pf_busy(o_pf_busy), .o_pf_done(o_pf_done), .o_dec_valid(o_dec_valid),
    .o_dec_word(o_dec_word), .o_dec_fault(o_dec_fault), .o_word_c(o_word_c),
    .o_valid_c(o_valid_c), .o_word_b(o_word_b), .o_valid_b(o_valid_b), .o_ic_req(o_ic_req),
    .o_ic_addr(ic_addr), .i_ic_hit(ic_hit), .i_ic_data(ic_data), .o_bc_req(o_bc_req),
    .o_bc_addr(bc_addr), .o_bc_abort(o_bc_abort), .i_bc_done(bc_done), .i_bc_err(bc_err),
    .i_bc_data(bc_data));
  ipp_far far_u (.i_clk_sys(i_clk_sys), .i_nrst(i_nrst), .i_ic_req(o_ic_req),
    .i_ic_addr(ic_addr), .i_bc_req(o_bc_req), .i_bc_addr(bc_addr), .i_bc_abort(o_bc_abort),
    .i_ic_en(ic_en), .i_lat(lat), .i_err_la(err_la), .o_ic_hit(ic_hit), .o_ic_data(ic_data),
    .o_bc_done(bc_done), .o_bc_err(bc_err), .o_bc_data(bc_data));
  // The 125 MHz system clock.
  initial begin
    i_clk_sys = 1'b0;
    forever #4 i_clk_sys = ~i_clk_sys;
  end
  // Every comparison passes through here, so nothing goes uncounted.
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic give_verdict;
    if (n_mismatch == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // Words of empty stages are left unchecked, since a flush clears valid and fault but keeps the word.
  task automatic cmp_pipe;
    logic [15:0] sw[3];
    logic sv[3];
    sw = '{o_word_b, o_word_c, o_dec_word};
    sv = '{o_valid_b, o_valid_c, o_dec_valid};
    for (int i = 0; i < 3; i++) begin
      chk("stage valid", 16'(sv[i]), 16'(pv[i]));
      if (pv[i] != 0) chk("stage word", sw[i], 16'(pw[i]));
    end
    chk("dec fault", 16'(o_dec_fault), 16'(pv[2] & pft[2]));
  endtask
  // One prefetch: raise the request for one cycle, wait for the word, then check.
  task automatic pf(input logic [31:0] ad);
    int n;
    logic hh;
    hh = hv != 0 && h_la == ad[31:2];
    @(posedge i_clk_sys);
    lat <= 8'($urandom_range(1, 6));
    i_pf_req <= 1'b1;
    i_pf_addr <= ad;
    #1;
    chk("ic req", 16'(o_ic_req), 16'h0001);
    chk("bc req", 16'(o_bc_req), 16'h0001);
    chk("bc abort", 16'(o_bc_abort), 16'(hh));
    chk("req addr", 16'(ic_addr == ad && bc_addr == ad), 16'h0001);
    for (n = 0; o_pf_done !== 1'b1 && n < 50; n++) begin
      @(posedge i_clk_sys);
      i_pf_req <= 1'b0;
      #1;
    end
    if (n == 50) begin
      n_mismatch++;
      give_verdict;
    end
    @(posedge i_clk_sys);
    i_pf_req <= 1'b0;
    for (int i = 2; i > 0; i--) begin
      pv[i] = pv[i-1];
      pw[i] = pw[i-1];
      pft[i] = pft[i-1];
    end
    pv[0] = 1;
    pw[0] = ad[1] ? ad[17:2] ^ 16'h3c3c : ad[17:2] ^ 16'ha5a5;
    pft[0] = ad[31:2] == err_la;
    hv = 1;
    h_la = ad[31:2];
    #1;
    cmp_pipe;
    chk("busy", 16'(o_pf_busy), 16'h0000);
  endtask
  initial begin
    void'($urandom(32'h2ba3d64e));
    repeat (10) @(posedge i_clk_sys);
    i_nrst <= 1'b1;
    #1;
    cmp_pipe;
    // Cache off, then on: holder hits must abort the bus either way.
    for (int e = 0; e < 2; e++) begin
      ic_en = e[0];
      for (int k = 0; k < 3; k++) begin
        a = $urandom & 32'hffff_fffc;
        pf(a);
        pf(a + 32'h2);
        pf(a + 32'ha);
        pf(a + 32'h8);
        pf(a);
      end
    end
    // A faulted long word reaches D flagged, then decode takes it.
    a = $urandom & 32'hffff_fffc;
    err_la = a[31:2];
    pf(a);
    pf(a + 32'h2);
    pf(a + 32'h4);
    err_la = 30'h3fff_ffff;
    @(posedge i_clk_sys);
    i_consume <= 1'b1;
    @(posedge i_clk_sys);
    i_consume <= 1'b0;
    pv[2] = 0;
    #1;
    cmp_pipe;
    // Flow change empties everything; the rerun refetches the faulted long word from the bus, now without fault.
    @(posedge i_clk_sys);
    i_flow_change <= 1'b1;
    @(posedge i_clk_sys);
    i_flow_change <= 1'b0;
    pv = '{0, 0, 0};
    hv = 0;
    #1;
    cmp_pipe;
    pf(a + 32'h2);
    // A flow change during a bus fetch cancels it; the late bus answer must not load B.
    @(posedge i_clk_sys);
    lat <= 8'h06;
    i_pf_req <= 1'b1;
    i_pf_addr <= a + 32'h40;
    @(posedge i_clk_sys);
    i_pf_req <= 1'b0;
    i_flow_change <= 1'b1;
    #1;
    chk("busy", 16'(o_pf_busy), 16'h0001);
    @(posedge i_clk_sys);
    i_flow_change <= 1'b0;
    pv = '{0, 0, 0};
    hv = 0;
    #1;
    chk("busy", 16'(o_pf_busy), 16'h0000);
    repeat (8) @(posedge i_clk_sys);
    #1;
    cmp_pipe;
    give_verdict;
  end
endmodule
